// *** acc_pkg.sv ***
// package: constants and types of the converter bus host
// Summary of operation
// - both selects must be low for the converter to read or convert
// - host holds a select low at least 300 ns to start a conversion
// - stand-alone: selects driven together, direction low requests conversion
// - single stand-alone: host raises direction after conversion starts
// - continuous: raise direction only while status is high; host ignores status once a stop meets cnt >= CONT_CYCLES + CONV_CYCLES * 2
// - continuous direction low pulse lasts at least 10.25 us
// - host takes coding and polarity selects from the start write, so they can change on the same edge as the selects fall
package acc_pkg;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int WRITE_PULSE_NS = 300;
  localparam int BUS_ACCESS_DELAY_NS = 250;
  localparam int OUTPUT_FLOAT_DELAY_NS = 150;
  localparam int CONVERT_START_DELAY_NS = 700;
  localparam int CONV_TIME_NS = 10000;
  localparam int CONT_PULSE_PS = 10250000;
  localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ACCESS_CYC = (BUS_ACCESS_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FLOAT_CYC = (OUTPUT_FLOAT_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int START_CYC = (CONVERT_START_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CONV_CYC = (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CONT_CYC = (CONT_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_DATA = 4'h8;
  localparam logic [3:0] REG_COUNT = 4'hc;
  localparam int CTRL_START = 0;
  localparam int CTRL_CONT = 1;
  localparam int CTRL_STOP = 2;
  localparam int CTRL_POL = 3;
  localparam int CTRL_CODE = 4;
  localparam logic [7:0] DATA_RESET = 8'h00;

  typedef struct packed {
    logic sel_a_n;
    logic sel_b_n;
    logic dir;
    logic polarity;
    logic coding;
  } acc_pins_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } acc_req_type;

  typedef enum {
    ST_IDLE, ST_CONV_PULSE, ST_CONV_WAIT, ST_CONT, ST_CONT_END, ST_READ, ST_RELEASE
  } acc_state_type;
endpackage

// *** acc_host.sv ***
// host controller that drives the converter pins
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module acc_host #(
  parameter int CONV_CYCLES = acc_pkg::CONV_CYC,
  parameter int CONT_CYCLES = acc_pkg::CONT_CYC
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire acc_pkg::acc_req_type req,
  output logic [31:0] rdata,
  output acc_pkg::acc_pins_type pins,
  input wire logic status_in,
  input wire logic [7:0] data_in,
  output logic busy
);
  import acc_pkg::*;

  // ------------------------------------------------------------
  // parameter check
  // ------------------------------------------------------------
  // the cycle counter is 24 bits wide; the longest wait must fit
  if (CONV_CYCLES < 2 || CONT_CYCLES <= CONV_CYCLES ||
      CONT_CYCLES + CONV_CYCLES * 2 >= 24'hffffff) begin : g_bad_cycles
    $error("acc_host: bad cycle counts");
  end

  // ------------------------------------------------------------
  // status pin synchroniser
  // ------------------------------------------------------------
  // a change counts once the second and third flops agree
  logic [2:0] stat_sync;
  logic stat_q;
  wire stat_agree = (stat_sync[1] == stat_sync[2]);
  wire stat_next = stat_agree ? stat_sync[1] : stat_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stat_sync <= 3'h0;
      stat_q <= 1'b0;
    end else begin
      stat_sync <= {stat_sync[1:0], status_in};
      stat_q <= stat_next;
    end
  end
  // edges of the filtered status
  wire stat_rise = stat_next & ~stat_q;
  wire stat_fall = ~stat_next & stat_q;

  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------
  acc_state_type state, next_state;
  logic [23:0] cnt, next_cnt;
  logic [7:0] result;
  logic [15:0] conv_count;
  logic pol, code, stop_req, timeout;
  wire ctrl_wr = req.wr && req.addr == REG_CTRL;
  wire go_single = ctrl_wr && req.wdata[CTRL_START] && state == ST_IDLE;
  wire go_cont = ctrl_wr && req.wdata[CTRL_CONT] && state == ST_IDLE;
  wire go_stop = ctrl_wr && req.wdata[CTRL_STOP];
  wire idle = state == ST_IDLE;
  // unmapped addresses read as zero
  wire [31:0] rd_mux =
    req.addr == REG_STATUS ? {29'h0, timeout, stat_q, ~idle} :
    req.addr == REG_DATA ? {24'h0, result} :
    req.addr == REG_COUNT ? {16'h0, conv_count} :
    req.addr == REG_CTRL ? {27'h0, code, pol, 3'h0} : 32'h0;

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  // pin levels follow the current state and are registered at the outputs
  logic sel_n, dir;
  always_comb begin
    next_state = state;
    next_cnt = cnt + 24'h1;
    sel_n = 1'b1;
    dir = 1'b1;
    unique case (state)
      ST_IDLE: begin
        next_cnt = 24'h0;
        if (go_single || go_cont) begin
          next_state = go_cont ? ST_CONT : ST_CONV_PULSE;
        end
      end
      ST_CONV_PULSE: begin
        sel_n = 1'b0;
        dir = 1'b0;
        if (cnt >= 24'(WRITE_PULSE_CYC + START_CYC)) begin
          next_state = ST_CONV_WAIT;
          next_cnt = 24'h0;
        end
      end
      ST_CONV_WAIT: begin
        sel_n = 1'b0;
        // direction back high so result is driven at completion
        if ((cnt > 24'(START_CYC) && stat_fall) || cnt >= 24'(CONV_CYCLES * 2)) begin
          next_state = ST_READ;
          next_cnt = 24'h0;
        end
      end
      ST_CONT: begin
        sel_n = 1'b0;
        dir = 1'b0;
        // raise direction right after status rises
        // a late filtered level could already have fallen at the pin
        if (stop_req && cnt >= 24'(CONT_CYCLES) && stat_rise) begin
          next_state = ST_CONT_END;
          next_cnt = 24'h0;
        end else if (stop_req && cnt >= 24'(CONT_CYCLES + CONV_CYCLES * 2)) begin
          // stop past CONT_CYCLES + CONV_CYCLES * 2 with no status rise this cycle: leave, wait ends on status fall or time out
          next_state = ST_CONT_END;
          next_cnt = 24'h0;
        end
      end
      ST_CONT_END: begin
        sel_n = 1'b0;
        if (stat_fall || cnt >= 24'(CONV_CYCLES * 2)) begin
          next_state = ST_READ;
          next_cnt = 24'h0;
        end
      end
      ST_READ: begin
        sel_n = 1'b0; // hold selects through access time
        if (cnt >= 24'(ACCESS_CYC + 2)) begin
          next_state = ST_RELEASE;
          next_cnt = 24'h0;
        end
      end
      ST_RELEASE: begin
        if (cnt >= 24'(FLOAT_CYC)) begin // wait for bus float
          next_state = ST_IDLE;
        end
      end
    endcase
  end
  // sample the bus on the last read cycle, well past the access time
  wire capture = state == ST_READ && cnt == 24'(ACCESS_CYC + 2);
  // give up after twice the conversion time
  wire tmo_next = (state == ST_CONV_WAIT || state == ST_CONT_END) &&
    cnt >= 24'(CONV_CYCLES * 2);

  // ------------------------------------------------------------
  // registers: sequencer state and cycle counter
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      cnt <= 24'h0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // ------------------------------------------------------------
  // configuration and stop request
  // ------------------------------------------------------------
  // coding and polarity only change between conversions
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pol <= 1'b0;
      code <= 1'b0;
    end else if (ctrl_wr && idle) begin
      pol <= req.wdata[CTRL_POL];
      code <= req.wdata[CTRL_CODE];
    end
  end

  // a stop written in the same cycle as the idle clear is kept
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stop_req <= 1'b0;
    end else if (go_stop) begin
      stop_req <= 1'b1;
    end else if (idle) begin
      stop_req <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // result, conversion count and timeout flag
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      result <= DATA_RESET;
    end else if (capture) begin
      result <= data_in;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_count <= 16'h0;
    end else if (stat_rise) begin
      conv_count <= conv_count + 16'h1;
    end
  end

  // sticky until the next start
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      timeout <= 1'b0;
    end else if (tmo_next) begin
      timeout <= 1'b1;
    end else if (go_single || go_cont) begin
      timeout <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 32'h0;
      pins <= '{sel_a_n: 1'b1, sel_b_n: 1'b1, dir: 1'b1, polarity: 1'b0, coding: 1'b0};
      busy <= 1'b0;
    end else begin
      rdata <= req.rd ? rd_mux : 32'h0;
      pins <= '{sel_a_n: sel_n, sel_b_n: sel_n, dir: dir, polarity: pol, coding: code};
      busy <= next_state != ST_IDLE;
    end
  end
endmodule

// *** acc_host_assertions.sv ***
// checker of the pin rules kept by the host
`timescale 1ns/1ps
module acc_host_assertions (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire acc_pkg::acc_req_type req,
  input wire logic [31:0] rdata,
  input wire acc_pkg::acc_pins_type pins,
  input wire logic status_in,
  input wire logic [7:0] data_in,
  input wire logic busy
);
  import acc_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_sel_tied: assert property (pins.sel_a_n == pins.sel_b_n) else $error("selects split");
  a_sel_long: assert property ($rose(pins.sel_a_n) |-> !$past(pins.sel_a_n, 62))
    else $error("select pulse short");
  a_idle_off: assert property (!busy |-> pins.sel_a_n && pins.dir) else $error("idle pins");
  a_start_pins: assert property (req.wr && req.addr == REG_CTRL && req.wdata[0] && !busy
    |=> ##1 !pins.sel_a_n && !pins.dir) else $error("no start");
  a_dir_conv: assert property ($rose(pins.dir) && !pins.sel_a_n |-> status_in)
    else $error("dir rose outside conversion");
  a_dir_width: assert property ($rose(pins.dir) && !pins.sel_a_n |-> !$past(pins.dir, 20))
    else $error("dir low too short");
  a_cfg_hold: assert property (!pins.sel_a_n && !$past(pins.sel_a_n)
    |-> $stable({pins.polarity, pins.coding})) else $error("config moved");
endmodule
bind acc_host acc_host_assertions i_chk (.ref_clk, .reset_n, .req, .rdata, .pins, .status_in,
  .data_in, .busy);

// *** acc_conv_model.sv ***
// behavioural converter at the far side of the host
`timescale 1ns/1ps
module acc_conv_model #(
  parameter int CONV_CYC = 200
) (
  input wire logic ref_clk,
  input wire acc_pkg::acc_pins_type pins,
  input wire logic [7:0] sample,
  output logic status,
  output logic [7:0] data
);
  import acc_pkg::*;
  int low_cnt = 0;
  int conv_cnt = 0;
  int hold = 0;
  logic done = 1'b0;
  logic [7:0] res = 8'h00;
  wire sel_on = !pins.sel_a_n && !pins.sel_b_n;
  wire cnv_req = sel_on && !pins.dir;
  wire rd_on = sel_on && pins.dir && !status && done;
  // released bus shows the inverse of the last value
  assign data = (hold != 0) ? res : ~res;
  initial status = 1'b0;
  always @(posedge ref_clk) begin
    low_cnt <= cnv_req ? low_cnt + 1 : 0;
    hold <= rd_on ? 7 : (hold != 0) ? hold - 1 : 0;
    if (!status && cnv_req && low_cnt >= 74) begin
      status <= 1'b1;
      conv_cnt <= 0;
      done <= 1'b0;
      res <= sample ^ {pins.coding, 7'h00};
    end else if (status) begin
      conv_cnt <= conv_cnt + 1;
      if (conv_cnt == CONV_CYC - 1) begin
        status <= 1'b0;
        done <= 1'b1;
        if (cnv_req) low_cnt <= 70;
      end
    end
  end
endmodule

// *** acc_host_tb.sv ***
// testbench of the converter bus host
`timescale 1ns/1ps
module acc_host_tb;
  import acc_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  acc_req_type req = '0;
  logic [31:0] rdata;
  acc_pins_type pins;
  logic status_in;
  logic [7:0] data_in;
  logic busy;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  always #2 ref_clk = ~ref_clk;
  acc_host #(.CONV_CYCLES(400), .CONT_CYCLES(450)) i_dut (.ref_clk, .reset_n, .req, .rdata,
    .pins, .status_in, .data_in, .busy);
  // conversion long enough that its end falls past the host's start window
  acc_conv_model #(.CONV_CYC(400)) i_dev (.ref_clk, .pins, .sample(8'hc3),
    .status(status_in), .data(data_in));
  task automatic conclude;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge ref_clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge ref_clk);
    req.rd <= 1'b0;
    #1;
    chk(rdata, e);
    @(posedge ref_clk);
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 3000; i++) begin
      @(negedge ref_clk);
      if (busy === 1'b0) break;
    end
    chk({31'h0, busy}, 32'h0);
    @(posedge ref_clk);
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    rd(REG_STATUS, 32'h0);
    rd(4'h2, 32'h0);
    // every coding mode, with a start refused while busy
    for (int m = 0; m < 4; m++) begin
      wr(REG_CTRL, {27'h0, m[1:0], 3'b001});
      @(posedge ref_clk);
      wr(REG_CTRL, {27'h0, ~m[1:0], 3'b001});
      wait_idle();
      rd(REG_CTRL, {27'h0, m[1:0], 3'b000});
      rd(REG_DATA, {24'h0, 8'hc3 ^ {m[1], 7'h00}});
      rd(REG_COUNT, m + 1);
      rd(REG_STATUS, 32'h0);
      chk({30'h0, pins.polarity, pins.coding}, {30'h0, m[0], m[1]});
    end
    // continuous run stopped in its second conversion
    wr(REG_CTRL, 32'h12);
    repeat (300) @(posedge ref_clk);
    wr(REG_CTRL, 32'h4);
    wait_idle();
    rd(REG_COUNT, 32'h6);
    rd(REG_DATA, 32'h43);
    rd(REG_STATUS, 32'h0);
    conclude();
  end
endmodule
